/* File: design/fvcfg_burst_addr.sv */
// Byte address walker for wrapped and sequential burst reads.
`timescale 1ns/100ps
module fvcfg_burst_addr
(
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic start, // Pulse: load start address and wrap mode.
  input wire logic [23:0] start_addr, // Three-byte address after the command.
  input wire fvcfg_pkg::fvcfg_wrap_t wrap_in, // Wrap mode from the register.
  input wire logic adv, // Pulse: one byte has been sent.
  output logic [23:0] addr_r // Address of the byte being sent.
);

  fvcfg_pkg::fvcfg_wrap_t mode_r;
  fvcfg_pkg::fvcfg_wrap_t mode_nxt;
  logic [23:0] addr_nxt;
  logic [23:0] inc;
  logic [23:0] msk;

  // Mask of the offset bits inside the aligned block.
  function automatic logic [23:0] wrap_mask(fvcfg_pkg::fvcfg_wrap_t m);
    if (m == fvcfg_pkg::fvcfg_wrap_16)
      return fvcfg_pkg::fvcfg_mask_16;
    else if (m == fvcfg_pkg::fvcfg_wrap_32)
      return fvcfg_pkg::fvcfg_mask_32;
    else if (m == fvcfg_pkg::fvcfg_wrap_64)
      return fvcfg_pkg::fvcfg_mask_64;
    else
      return 24'hffffff;
  endfunction : wrap_mask

  // The mode is frozen at start so a register write mid-burst cannot tear it.
  always_comb
  begin
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    msk = wrap_mask(mode_r);
    inc = addr_r + 24'h000001;
    if (start)
    begin
      mode_nxt = wrap_in;
      addr_nxt = start_addr;
    end
    else if (adv)
    begin
      addr_nxt = (addr_r & ~msk) | (inc & msk);
    end
  end

  // Register the walker state.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mode_r <= fvcfg_pkg::fvcfg_wrap_seq;
      addr_r <= 24'h000000;
    end
    else
    begin
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
    end
  end

  property p_seq_step;
    @(posedge mclk) disable iff (srst)
    (adv && !start && mode_r == fvcfg_pkg::fvcfg_wrap_seq)
      |=> addr_r == $past(addr_r) + 24'h000001;
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("Sequential step wrong.");

  property p_wrap_stay;
    @(posedge mclk) disable iff (srst)
    (adv && !start && mode_r == fvcfg_pkg::fvcfg_wrap_16)
      |=> addr_r[23:4] == $past(addr_r[23:4]) &&
          addr_r[3:0] == $past(addr_r[3:0]) + 4'h1;
  endproperty
  a_wrap_stay: assert property (p_wrap_stay)
    else $error("Wrap left block.");

  property p_start_load;
    @(posedge mclk) disable iff (srst)
    start |=> addr_r == $past(start_addr);
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("Start not loaded.");

endmodule : fvcfg_burst_addr

/* File: design/fvcfg_pkg.sv */
// Constants and types shared by the volatile configuration register bank.
//
// Contract
// - First register bits 7:4 set dummy clocks; 0000 and 1111 are default.
// - First register bit 3 low enables execute-in-place; resets high.
// - Feature option 2 or 4 forces execute-in-place, ignoring bit 3.
// - Bits 1:0 pick wrap 16, 32, 64 bytes, or sequential (11, default).
// - Wrapped read starts at given address, wraps in its aligned block.
// - Sequential setting returns consecutive addresses with no wrapping.
// - First register uses its own commands; writes act on completion.
// - Second register bit 7 low enables quad, bit 6 low dual.
// - Both low means quad; change applies to the following transfer.
// - Second register bit 4 high enables the hold or reset function.
// - Second register bit 3 low enables program voltage acceleration.
// - Bits 2:0 select drive strength; 000 and 100 are reserved.
// - Second register is readable and writable in every protocol.
// - Both registers return to defaults on reset.
package fvcfg_pkg;

  // Register selects carried with each register command.
  localparam logic fvcfg_sel_read_behavior = 1'b0;
  localparam logic fvcfg_sel_protocol_drive = 1'b1;

  // Field positions of read_behavior_config.
  localparam int fvcfg_rb_dummy_hi = 7;
  localparam int fvcfg_rb_dummy_lo = 4;
  localparam int fvcfg_rb_exec_dis = 3;
  localparam int fvcfg_rb_wrap_hi = 1;
  localparam int fvcfg_rb_wrap_lo = 0;
  localparam logic [7:0] fvcfg_rb_rsvd_mask = 8'h04;
  localparam logic [7:0] fvcfg_rb_reset = 8'hfb;

  // Field positions of protocol_drive_config.
  localparam int fvcfg_pd_quad_dis = 7;
  localparam int fvcfg_pd_dual_dis = 6;
  localparam int fvcfg_pd_hold_en = 4;
  localparam int fvcfg_pd_vpp_dis = 3;
  localparam int fvcfg_pd_drv_hi = 2;
  localparam int fvcfg_pd_drv_lo = 0;
  localparam logic [7:0] fvcfg_pd_rsvd_mask = 8'h20;
  localparam logic [7:0] fvcfg_pd_reset = 8'hdf;

  // Dummy clock codes that both stand for the default count.
  localparam logic [3:0] fvcfg_dummy_dflt_a = 4'h0;
  localparam logic [3:0] fvcfg_dummy_dflt_b = 4'hf;

  // Feature options that always run execute-in-place.
  localparam logic [3:0] fvcfg_feat_exec_a = 4'h2;
  localparam logic [3:0] fvcfg_feat_exec_b = 4'h4;

  // Drive strength codes that are reserved.
  localparam logic [2:0] fvcfg_drv_rsvd_a = 3'h0;
  localparam logic [2:0] fvcfg_drv_rsvd_b = 3'h4;

  // Wrap masks for the aligned block sizes.
  localparam logic [23:0] fvcfg_mask_16 = 24'h00000f;
  localparam logic [23:0] fvcfg_mask_32 = 24'h00001f;
  localparam logic [23:0] fvcfg_mask_64 = 24'h00003f;

  typedef enum logic [1:0]
  {
    fvcfg_wrap_16,
    fvcfg_wrap_32,
    fvcfg_wrap_64,
    fvcfg_wrap_seq
  } fvcfg_wrap_t;

  typedef enum logic [1:0]
  {
    fvcfg_proto_single,
    fvcfg_proto_dual,
    fvcfg_proto_quad
  } fvcfg_proto_t;

endpackage : fvcfg_pkg

/* File: design/fvcfg_regs.sv */
// Volatile configuration register bank with its decoded control outputs.
`timescale 1ns/100ps
module fvcfg_regs
#(
  parameter logic [3:0] FEATURE_OPT = 4'h0, // Feature option strap value.
  parameter logic [3:0] DEFAULT_DUMMY = 4'ha // Dummy clocks for default code.
)
(
  input wire logic mclk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic wr_done, // Pulse: a register write command completed.
  input wire logic wr_sel, // Register written by that command.
  input wire logic [7:0] wr_data, // Data byte of that command.
  input wire logic rd_req, // Pulse: a register read command wants data.
  input wire logic rd_sel, // Register to read.
  output logic [7:0] rd_data_r, // Read data byte.
  output logic rd_valid_r, // Pulse: rd_data_r is valid.
  input wire logic burst_start, // Pulse: a read begins at burst_addr.
  input wire logic [23:0] burst_addr, // Start address of the read.
  input wire logic burst_adv, // Pulse: one byte of the read was sent.
  output logic [23:0] burst_cur, // Address of the current byte.
  output logic [3:0] dummy_clks, // Dummy clocks after fast reads.
  output logic execute_in_place_on, // Execute-in-place active.
  output fvcfg_pkg::fvcfg_wrap_t wrap_mode, // Burst wrap mode.
  output fvcfg_pkg::fvcfg_proto_t protocol, // Protocol for next transfer.
  output logic hold_rst_en, // Hold or reset pin function on.
  output logic vpp_accel_en, // Program voltage acceleration on.
  output logic [2:0] drive_code, // Output driver strength code.
  output logic drive_rsvd // Drive code is a reserved value.
);

  logic [7:0] rb_r;
  logic [7:0] rb_nxt;
  logic [7:0] pd_r;
  logic [7:0] pd_nxt;
  logic [7:0] rd_data_nxt;
  logic rd_valid_nxt;
  logic exec_forced;
  logic [3:0] dcode;

  // Execute-in-place is forced on for the two feature options.
  assign exec_forced = (FEATURE_OPT == fvcfg_pkg::fvcfg_feat_exec_a) ||
                       (FEATURE_OPT == fvcfg_pkg::fvcfg_feat_exec_b);

  // Next register values; a write lands on the cycle its command completes.
  // Writes are accepted whatever protocol is active.
  always_comb
  begin
    rb_nxt = rb_r;
    pd_nxt = pd_r;
    if (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_read_behavior)
    begin
      rb_nxt = wr_data & ~fvcfg_pkg::fvcfg_rb_rsvd_mask;
    end
    else if (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_protocol_drive)
    begin
      pd_nxt = wr_data & ~fvcfg_pkg::fvcfg_pd_rsvd_mask;
    end
  end

  // Register the configuration; reset restores the defaults.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rb_r <= fvcfg_pkg::fvcfg_rb_reset;
      pd_r <= fvcfg_pkg::fvcfg_pd_reset;
    end
    else
    begin
      rb_r <= rb_nxt;
      pd_r <= pd_nxt;
    end
  end

  // Read answer one cycle after the request, from the selected register.
  always_comb
  begin
    rd_valid_nxt = rd_req;
    rd_data_nxt = rd_data_r;
    if (rd_req && rd_sel == fvcfg_pkg::fvcfg_sel_read_behavior)
    begin
      rd_data_nxt = rb_r;
    end
    else if (rd_req)
    begin
      rd_data_nxt = pd_r;
    end
  end

  // Register the read answer.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end
    else
    begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // Decode fields. The host alone guarantees the dummy count suits its
  // clock; nothing here can check that.
  assign dcode =
    rb_r[fvcfg_pkg::fvcfg_rb_dummy_hi:fvcfg_pkg::fvcfg_rb_dummy_lo];
  always_comb
  begin
    if (dcode == fvcfg_pkg::fvcfg_dummy_dflt_a ||
        dcode == fvcfg_pkg::fvcfg_dummy_dflt_b)
      dummy_clks = DEFAULT_DUMMY;
    else
      dummy_clks = dcode;
  end

  assign execute_in_place_on = exec_forced ||
    !rb_r[fvcfg_pkg::fvcfg_rb_exec_dis];
  assign wrap_mode = fvcfg_pkg::fvcfg_wrap_t'(
    rb_r[fvcfg_pkg::fvcfg_rb_wrap_hi:fvcfg_pkg::fvcfg_rb_wrap_lo]);

  // Quad wins when both protocol bits are cleared.
  always_comb
  begin
    if (!pd_r[fvcfg_pkg::fvcfg_pd_quad_dis])
      protocol = fvcfg_pkg::fvcfg_proto_quad;
    else if (!pd_r[fvcfg_pkg::fvcfg_pd_dual_dis])
      protocol = fvcfg_pkg::fvcfg_proto_dual;
    else
      protocol = fvcfg_pkg::fvcfg_proto_single;
  end

  assign hold_rst_en = pd_r[fvcfg_pkg::fvcfg_pd_hold_en];
  assign vpp_accel_en = !pd_r[fvcfg_pkg::fvcfg_pd_vpp_dis];
  assign drive_code =
    pd_r[fvcfg_pkg::fvcfg_pd_drv_hi:fvcfg_pkg::fvcfg_pd_drv_lo];
  assign drive_rsvd = (drive_code == fvcfg_pkg::fvcfg_drv_rsvd_a) ||
                      (drive_code == fvcfg_pkg::fvcfg_drv_rsvd_b);

  // Address walker for burst reads.
  fvcfg_burst_addr u_burst
  (
    .mclk(mclk),
    .srst(srst),
    .start(burst_start),
    .start_addr(burst_addr),
    .wrap_in(wrap_mode),
    .adv(burst_adv),
    .addr_r(burst_cur)
  );

  property p_dummy_dflt;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_read_behavior &&
     (wr_data[7:4] == 4'h0 || wr_data[7:4] == 4'hf))
      |=> dummy_clks == DEFAULT_DUMMY;
  endproperty
  a_dummy_dflt: assert property (p_dummy_dflt)
    else $error("Dummy default wrong.");

  // Any other code is the count itself; no translation table is kept.
  property p_dummy_pass;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_read_behavior &&
     wr_data[7:4] != 4'h0 && wr_data[7:4] != 4'hf)
      |=> dummy_clks == $past(wr_data[7:4]);
  endproperty
  a_dummy_pass: assert property (p_dummy_pass)
    else $error("Dummy count not passed through.");

  property p_exec_in_place;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_read_behavior)
      |=> execute_in_place_on == (exec_forced || !$past(wr_data[3]));
  endproperty
  a_exec_in_place: assert property (p_exec_in_place)
    else $error("Execute-in-place wrong.");

  // The wrap field must reach the walker exactly as written.
  property p_wrap_mode;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_read_behavior)
      |=> wrap_mode == $past(wr_data[1:0]);
  endproperty
  a_wrap_mode: assert property (p_wrap_mode)
    else $error("Wrap mode wrong.");

  property p_reset_vals;
    @(posedge mclk)
    srst |=> (rb_r == fvcfg_pkg::fvcfg_rb_reset &&
              pd_r == fvcfg_pkg::fvcfg_pd_reset && !rd_valid_r);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Reset values wrong.");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (srst)
    rd_valid_r |-> (rd_data_r[2] == 1'b0 ||
                    $past(rd_sel) == fvcfg_pkg::fvcfg_sel_protocol_drive) &&
                   (rd_data_r[5] == 1'b0 ||
                    $past(rd_sel) == fvcfg_pkg::fvcfg_sel_read_behavior);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved bit set.");

  property p_proto_next;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_protocol_drive &&
     wr_data[7:6] == 2'b00) |=> protocol == fvcfg_pkg::fvcfg_proto_quad;
  endproperty
  a_proto_next: assert property (p_proto_next)
    else $error("Quad not chosen.");

  // A read one idle cycle after a write returns the stored byte.
  property p_read_echo;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_protocol_drive ##1
     !wr_done && !rd_req ##1
     rd_req && rd_sel == fvcfg_pkg::fvcfg_sel_protocol_drive && !wr_done)
      |=> rd_valid_r &&
          rd_data_r == ($past(wr_data, 3) & ~fvcfg_pkg::fvcfg_pd_rsvd_mask);
  endproperty
  a_read_echo: assert property (p_read_echo)
    else $error("Read echo wrong.");

  property p_accel;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_protocol_drive)
      |=> vpp_accel_en == !$past(wr_data[3]) &&
          drive_code == $past(wr_data[2:0]);
  endproperty
  a_accel: assert property (p_accel)
    else $error("Accel or drive wrong.");

  // Reserved drive codes are flagged so the pad logic can ignore them.
  property p_drive_rsvd;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_protocol_drive)
      |=> drive_rsvd == ($past(wr_data[2:0]) == 3'h0 ||
                         $past(wr_data[2:0]) == 3'h4);
  endproperty
  a_drive_rsvd: assert property (p_drive_rsvd)
    else $error("Reserved drive code missed.");

  property p_hold;
    @(posedge mclk) disable iff (srst)
    (wr_done && wr_sel == fvcfg_pkg::fvcfg_sel_protocol_drive)
      |=> hold_rst_en == $past(wr_data[4]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Hold enable wrong.");

endmodule : fvcfg_regs

/* File: verification/fvcfg_host.sv */
// Host controller model that issues register and burst commands.
`timescale 1ns/100ps
module fvcfg_host
(
  input wire logic mclk, // System clock.
  output logic wr_done, // Write completion pulse.
  output logic wr_sel, // Register written.
  output logic [7:0] wr_data, // Byte written.
  output logic rd_req, // Read request pulse.
  output logic rd_sel, // Register read.
  output logic burst_start, // Burst start pulse.
  output logic [23:0] burst_addr, // Burst start address.
  output logic burst_adv, // Byte sent pulse.
  input wire logic [7:0] rd_data_r, // Read data.
  input wire logic rd_valid_r // Read data valid.
);
  // Idle values at time zero.
  initial
  begin
    {wr_done, wr_sel, wr_data, rd_req, rd_sel} = '0;
    {burst_start, burst_addr, burst_adv} = '0;
  end

  // One write; released lines show the inverse so stale data cannot pass.
  // The dummy count the caller picks must suit this host's clock.
  task automatic wr(input logic s, input logic [7:0] d);
    @(negedge mclk);
    wr_done = 1'b1;
    wr_sel = s;
    wr_data = d;
    @(negedge mclk);
    wr_done = 1'b0;
    wr_sel = ~s;
    wr_data = ~d;
  endtask : wr

  // One read; v is high only for a valid pulse of exactly one cycle.
  task automatic rd(input logic s, output logic [7:0] d, output logic v);
    @(negedge mclk);
    rd_req = 1'b1;
    rd_sel = s;
    @(negedge mclk);
    rd_req = 1'b0;
    rd_sel = ~s;
    d = rd_data_r;
    v = rd_valid_r;
    @(negedge mclk);
    v = v & ~rd_valid_r;
  endtask : rd

  // Start a burst at a, or with st low step one byte.
  task automatic bst(input logic st, input logic [23:0] a);
    @(negedge mclk);
    burst_start = st;
    burst_adv = ~st;
    burst_addr = a;
    @(negedge mclk);
    burst_start = 1'b0;
    burst_adv = 1'b0;
    burst_addr = ~a;
  endtask : bst
endmodule : fvcfg_host

/* File: verification/tb_flash_volatile_config_regs.sv */
// Self-checking bench for the volatile configuration register bank.
`timescale 1ns/100ps
module tb_flash_volatile_config_regs;
  typedef struct packed
  {
    logic s;
    logic [7:0] w;
    logic [7:0] r;
    logic [14:0] e;
  } fvcfg_row_t;
  // Write select, data, read-back and packed decoded outputs.
  fvcfg_row_t rows [13] = '{{1'b0, 8'h04, 8'h00, 15'h542e},
    {1'b0, 8'h59, 8'h59, 15'h292e}, {1'b0, 8'hf6, 8'hf2, 15'h562e},
    {1'b0, 8'he3, 8'he3, 15'h772e}, {1'b1, 8'hbf, 8'h9f, 15'h776e},
    {1'b1, 8'h3f, 8'h1f, 15'h77ae}, {1'b1, 8'h60, 8'h40, 15'h7791},
    {1'b1, 8'hcc, 8'hcc, 15'h7709}, {1'b1, 8'hd9, 8'hd9, 15'h7722},
    {1'b1, 8'hda, 8'hda, 15'h7724}, {1'b1, 8'hdb, 8'hdb, 15'h7726},
    {1'b1, 8'hdd, 8'hdd, 15'h772a}, {1'b1, 8'hde, 8'hde, 15'h772c}};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic wr_done, wr_sel, rd_req, rd_sel, burst_start, burst_adv;
  logic rd_valid_r, v, execute_in_place_on, hold_rst_en, vpp_accel_en;
  logic drive_rsvd;
  wire logic [1:0] exec_opt;
  logic [2:0] drive_code;
  logic [3:0] dummy_clks;
  logic [7:0] wr_data, rd_data_r, d;
  logic [14:0] outs;
  logic [23:0] burst_addr, burst_cur, a, m;
  fvcfg_pkg::fvcfg_wrap_t wrap_mode;
  fvcfg_pkg::fvcfg_proto_t protocol;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;

  // Clock and the packed view of every decoded output.
  always #5 mclk = ~mclk;
  assign outs = {dummy_clks, execute_in_place_on, wrap_mode, protocol,
    hold_rst_en, vpp_accel_en, drive_code, drive_rsvd};

  fvcfg_host fvcfg_host_i (.mclk, .wr_done, .wr_sel, .wr_data, .rd_req,
    .rd_sel, .burst_start, .burst_addr, .burst_adv, .rd_data_r, .rd_valid_r);
  fvcfg_regs fvcfg_regs_i (.mclk, .srst, .wr_done, .wr_sel, .wr_data,
    .rd_req, .rd_sel, .rd_data_r, .rd_valid_r, .burst_start, .burst_addr,
    .burst_adv, .burst_cur, .dummy_clks, .execute_in_place_on, .wrap_mode,
    .protocol, .hold_rst_en, .vpp_accel_en, .drive_code, .drive_rsvd);
  // Two variants that always run execute-in-place share the stimulus.
  for (genvar g = 0; g < 2; g++)
  begin : g_opt
    fvcfg_regs #(.FEATURE_OPT(g ? 4'h4 : 4'h2)) fvcfg_regs_i (.mclk, .srst,
      .wr_done, .wr_sel, .wr_data, .rd_req, .rd_sel, .rd_data_r(),
      .rd_valid_r(), .burst_start, .burst_addr, .burst_adv, .burst_cur(),
      .dummy_clks(), .execute_in_place_on(exec_opt[g]), .wrap_mode(),
      .protocol(), .hold_rst_en(), .vpp_accel_en(), .drive_code(),
      .drive_rsvd());
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic final_report;
    $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // A hang is cut short well beyond the roughly 113 cycles needed.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      final_report;
    end
  end

  initial
  begin
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    chk(outs, 15'h532e);
    chk(exec_opt, 2'h3);
    fvcfg_host_i.rd(1'b0, d, v);
    chk({d, v}, {8'hfb, 1'b1});
    fvcfg_host_i.rd(1'b1, d, v);
    chk({d, v}, {8'hdf, 1'b1});
    $display("reset test done");
    // Each row writes one register, then checks outputs and read-back.
    for (int i = 0; i < 13; i++)
    begin
      fvcfg_host_i.wr(rows[i].s, rows[i].w);
      chk(outs[14:8], rows[i].e[14:8]);
      chk(outs[7:0], rows[i].e[7:0]);
      fvcfg_host_i.rd(rows[i].s, d, v);
      chk({d, v}, {rows[i].r, 1'b1});
    end
    $display("row test done");
    // Every wrap mode from a block's last byte; a write mid-burst is ignored.
    for (int w = 0; w < 4; w++)
    begin
      fvcfg_host_i.wr(1'b0, {4'ha, 2'b10, w[1:0]});
      m = (24'h10 << w) - 24'h1;
      a = 24'habcdff;
      fvcfg_host_i.bst(1'b1, a);
      chk(burst_cur, a);
      fvcfg_host_i.wr(1'b0, 8'ha8);
      fvcfg_host_i.bst(1'b0, a);
      a = (w == 3) ? a + 24'h1 : (a & ~m) | ((a + 24'h1) & m);
      chk(burst_cur, a);
    end
    $display("burst test done");
    // A second reset in mid-run restores the defaults.
    @(negedge mclk);
    srst = 1'b1;
    @(negedge mclk);
    srst = 1'b0;
    chk(outs, 15'h532e);
    chk(burst_cur, 24'h0);
    $display("second reset test done");
    final_report;
  end
endmodule : tb_flash_volatile_config_regs
